// [inc/clock_gating_map.vh]
// Purpose: Offsets, fields, reset values and timing for clock gating control
// Assumes: AHB-Lite word registers, 32-bit data
// Notes: Behaviour list below
//
// Behaviour
// [RULE_01] Select clear: low-power clocks follow run set
// [RULE_02] Select set: sleep/deep-sleep sets decide clocks
// [RULE_03] Deep-sleep bit clear stops clock when gated
// [RULE_04] Deep-sleep exit resumes run peripherals, state kept
// [RULE_05] Deep-sleep bit set keeps clock when gated
// [RULE_06] Select clear keeps deep-sleep bits, unapplied
// [RULE_07] Run-disabled peripheral: no clock, no access
// [RULE_08] Regulator resets to 2.5 V, +/-10% steps
// [RULE_09] Run enables cleared at power-up
// [RULE_10] Access before five cycles after enable faults
// [RULE_11] Three enable sets chosen by power mode
`ifndef CLOCK_GATING_MAP_VH
`define CLOCK_GATING_MAP_VH
`define RUN_ENABLE_OFS 8'h00
`define SLEEP_ENABLE_OFS 8'h04
`define DEEP_SLEEP_ENABLE_OFS 8'h08
`define GATING_CTRL_OFS 8'h0c
`define REGULATOR_OFS 8'h10
`define READY_STATUS_OFS 8'h14
`define GATING_SELECT_BIT 0
`define REGULATOR_WIDTH 4
// Code n means 2.25 V + n * 50 mV; 11 codes span 2.25..2.75 V
`define REGULATOR_MAX 4'ha
`define REGULATOR_LEVEL_DEFAULT 4'h5
`define ENABLE_DELAY_CYCLES 3'h5
`define ENABLE_DELAY_WIDTH 3
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'b0
`define HRESP_ERROR 1'b1
`endif

// [rtl/peripheral_clock_gating_control.v]
// Purpose: Per-peripheral run/sleep/deep-sleep clock enables and access gates
// Assumes: Single AHB-Lite master, word accesses, power mode inputs in sync
// Notes: Clock gating cells are latch-free enables; gate cells sit outside
`timescale 1ns/100ps
`include "clock_gating_map.vh"
module peripheral_clock_gating_control #(
  parameter NUM_PERIPH = 32
)(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire sleep_mode,
  input wire deep_sleep_mode,
  input wire [NUM_PERIPH-1:0] periph_access_req,
  output reg [NUM_PERIPH-1:0] periph_clock_enable,
  output reg [NUM_PERIPH-1:0] periph_access_enable,
  output reg [NUM_PERIPH-1:0] periph_bus_fault,
  output reg [`REGULATOR_WIDTH-1:0] regulator_level_setting
);

  reg [NUM_PERIPH-1:0] run_enable_reg;
  reg [NUM_PERIPH-1:0] sleep_enable_reg;
  reg [NUM_PERIPH-1:0] deep_sleep_enable_reg;
  reg low_power_gating_select_reg;
  reg [NUM_PERIPH-1:0] ready_reg;
  reg wr_pend_reg;
  reg [7:0] addr_reg;
  reg [NUM_PERIPH-1:0] clk_next;
  reg [31:0] rdata_next;
  wire addr_phase;

  // A transfer starts on a selected NONSEQ or SEQ beat with the bus ready
  assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ |
                      htrans == `HTRANS_SEQ);

  // Bus address capture and data-phase write; slave is always zero-wait
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        addr_reg <= haddr;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end
  end

  // Configuration registers written during the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_enable_reg <= {NUM_PERIPH{1'b0}}; // see [RULE_09]
      sleep_enable_reg <= {NUM_PERIPH{1'b0}};
      deep_sleep_enable_reg <= {NUM_PERIPH{1'b0}};
      low_power_gating_select_reg <= 1'b0;
      regulator_level_setting <= `REGULATOR_LEVEL_DEFAULT; // see [RULE_08]
    end
    else if (wr_pend_reg)
    begin
      case (addr_reg)
        `RUN_ENABLE_OFS:
          run_enable_reg <= hwdata[NUM_PERIPH-1:0];
        `SLEEP_ENABLE_OFS:
          sleep_enable_reg <= hwdata[NUM_PERIPH-1:0];
        `DEEP_SLEEP_ENABLE_OFS:
          // Kept regardless of the gating select
          deep_sleep_enable_reg <= hwdata[NUM_PERIPH-1:0]; // see [RULE_06]
        `GATING_CTRL_OFS:
          low_power_gating_select_reg <= hwdata[`GATING_SELECT_BIT];
        `REGULATOR_OFS:
          // Out-of-range codes ignored, keeping +/-10% span; see [RULE_08]
          if (hwdata[`REGULATOR_WIDTH-1:0] <= `REGULATOR_MAX &&
              hwdata[31:`REGULATOR_WIDTH] == 28'h0000000)
            regulator_level_setting <= hwdata[`REGULATOR_WIDTH-1:0];
        default:
          run_enable_reg <= run_enable_reg;
      endcase
    end
  end

  // Read mux; unmapped offsets and unused upper bits read zero
  always @*
  begin
    rdata_next = 32'h00000000;
    case (haddr)
      `RUN_ENABLE_OFS: rdata_next[NUM_PERIPH-1:0] = run_enable_reg;
      `SLEEP_ENABLE_OFS: rdata_next[NUM_PERIPH-1:0] = sleep_enable_reg;
      `DEEP_SLEEP_ENABLE_OFS:
        rdata_next[NUM_PERIPH-1:0] = deep_sleep_enable_reg;
      `GATING_CTRL_OFS: rdata_next[0] = low_power_gating_select_reg;
      `REGULATOR_OFS:
        rdata_next[`REGULATOR_WIDTH-1:0] = regulator_level_setting;
      `READY_STATUS_OFS: rdata_next[NUM_PERIPH-1:0] = ready_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Read data registered into the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_phase && !hwrite)
      hrdata <= rdata_next;
  end

  // Clock choice per power mode from the three enable sets
  always @*
  begin
    if (!low_power_gating_select_reg)
      clk_next = run_enable_reg; // see [RULE_01] [RULE_06]
    else if (deep_sleep_mode)
      // Cleared bit stops, set bit keeps running; see [RULE_03] [RULE_05]
      clk_next = deep_sleep_enable_reg; // see [RULE_02] [RULE_11]
    else if (sleep_mode)
      clk_next = sleep_enable_reg; // see [RULE_02] [RULE_11]
    else
      clk_next = run_enable_reg; // see [RULE_04] [RULE_11]
  end

  // Per-peripheral enable delay, access gate and fault
  genvar i;
  generate
    for (i = 0; i < NUM_PERIPH; i = i + 1)
    begin : g_periph
      reg [`ENABLE_DELAY_WIDTH-1:0] cnt_reg;
      // Count five cycles after enable; disable clears at once
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cnt_reg <= {`ENABLE_DELAY_WIDTH{1'b0}};
          ready_reg[i] <= 1'b0;
        end
        else if (!run_enable_reg[i])
        begin
          cnt_reg <= {`ENABLE_DELAY_WIDTH{1'b0}};
          ready_reg[i] <= 1'b0;
        end
        else if (cnt_reg != `ENABLE_DELAY_CYCLES - 3'h1)
        begin
          cnt_reg <= cnt_reg + 3'h1; // see [RULE_10]
          ready_reg[i] <= 1'b0;
        end
        else
          ready_reg[i] <= 1'b1; // see [RULE_10]
      end
      // Outputs registered; clocks only gate, state is never reset
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          periph_clock_enable[i] <= 1'b0;
          periph_access_enable[i] <= 1'b0;
          periph_bus_fault[i] <= 1'b0;
        end
        else
        begin
          periph_clock_enable[i] <= clk_next[i] & ready_reg[i]; // see [RULE_07]
          periph_access_enable[i] <= ready_reg[i]; // see [RULE_07]
          periph_bus_fault[i] <= periph_access_req[i] &
                                 run_enable_reg[i] & ~ready_reg[i]; // see [RULE_10]
        end
      end
    end
  endgenerate

endmodule

// [bench/power_partner.sv]
// Purpose: Processor power modes and peripheral touches
// Assumes: One clock
// Notes: Follows bench commands one edge late
`timescale 1ns/100ps
module power_partner (
  input wire hclk,
  input wire [1:0] mode_req,
  input wire [31:0] touch_req,
  output logic sleep_mode = 0,
  output logic deep_sleep_mode = 0,
  output logic [31:0] periph_access_req = 0
);
  // Modes and touches, registered as a real requester would
  always @(posedge hclk)
  begin
    sleep_mode <= mode_req[0];
    deep_sleep_mode <= mode_req[1];
    periph_access_req <= touch_req;
  end
endmodule

// [bench/gating_checker.sv]
// Purpose: Port checks for clock gating control
// Assumes: Single clock, async low reset
// Notes: Bound to the peripheral_clock_gating_control module
`timescale 1ns/100ps
module gating_checker #(
  parameter NUM_PERIPH = 32
)(
  input wire hclk,
  input wire hresetn,
  input wire hresp,
  input wire hreadyout,
  input wire sleep_mode,
  input wire deep_sleep_mode,
  input wire [NUM_PERIPH-1:0] periph_access_req,
  input wire [NUM_PERIPH-1:0] periph_clock_enable,
  input wire [NUM_PERIPH-1:0] periph_access_enable,
  input wire [NUM_PERIPH-1:0] periph_bus_fault,
  input wire [3:0] regulator_level_setting
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 0) else $error("resp");
  a_ready_high: assert property (hreadyout) else $error("wait");
  a_level_range: assert property (regulator_level_setting <= 4'ha)
    else $error("level");
  a_level_reset: assert property ($rose(hresetn) |->
    regulator_level_setting == 4'h5) else $error("level rst");
  a_run_off_reset: assert property ($rose(hresetn) |->
    periph_clock_enable == 0 && periph_access_enable == 0) else $error("run");
  a_run_clk_acc: assert property (!sleep_mode && !deep_sleep_mode &&
    !$past(sleep_mode) && !$past(deep_sleep_mode) |->
    periph_clock_enable == periph_access_enable) else $error("run clk");
  a_fault_has_req: assert property (
    (periph_bus_fault & ~$past(periph_access_req)) == 0) else $error("fault");
  a_fault_unready: assert property (
    (periph_bus_fault & $past(periph_access_enable)) == 0) else $error("rdy");
endmodule
bind peripheral_clock_gating_control gating_checker #(
  .NUM_PERIPH(NUM_PERIPH)
) chk_u (.hclk, .hresetn, .hresp, .hreadyout, .sleep_mode, .deep_sleep_mode,
  .periph_access_req, .periph_clock_enable, .periph_access_enable,
  .periph_bus_fault, .regulator_level_setting);

// [bench/tb_top.sv]
// Purpose: Register and gating scenarios
// Assumes: Zero wait AHB slave
// Notes: Mode change needs two edges to reach outputs
`timescale 1ns/100ps
`include "clock_gating_map.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0, mode = 0;
  logic [31:0] hwdata = 0, touch = 0, rd;
  wire [31:0] hrdata, acc, clk, flt, req;
  wire hreadyout, hresp, slp, dslp;
  wire [3:0] lvl;
  int error_cnt = 0, checked = 0;
  logic [1:0] md[3] = '{2'h1, 2'h2, 2'h0};
  logic [1:0] ex[3] = '{2'b01, 2'b10, 2'b11};
  always #2.5 hclk = ~hclk;
  peripheral_clock_gating_control dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .sleep_mode(slp), .deep_sleep_mode(dslp),
    .periph_access_req(req), .periph_clock_enable(clk),
    .periph_access_enable(acc), .periph_bus_fault(flt),
    .regulator_level_setting(lvl));
  power_partner pp_u (.hclk, .mode_req(mode), .touch_req(touch),
    .sleep_mode(slp), .deep_sleep_mode(dslp), .periph_access_req(req));
  task close_out;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++n > 50)
      begin
        error_cnt++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    hwrite <= w;
    haddr <= a;
    htrans <= `HTRANS_NONSEQ;
    wait_rdy;
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // Reset, then enable, regulator and gating scenarios
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    xfer(0, `REGULATOR_OFS, 0);
    `CHK("level", 32'h5, rd)
    xfer(0, `RUN_ENABLE_OFS, 0);
    `CHK("run", 32'h0, rd)
    xfer(1, `RUN_ENABLE_OFS, 32'h3);
    touch <= 32'h1;
    @(posedge hclk);
    touch <= 0;
    @(posedge hclk);
    #1;
    `CHK("fault", 1'b1, flt[0])
    repeat (8) @(posedge hclk);
    `CHK("acc", 3'b011, acc[2:0])
    `CHK("clk", 3'b011, clk[2:0])
    xfer(1, `REGULATOR_OFS, 32'ha);
    xfer(1, `REGULATOR_OFS, 32'hb);
    xfer(0, `REGULATOR_OFS, 0);
    `CHK("level", 32'ha, rd)
    `CHK("pin", 4'ha, lvl)
    xfer(1, `DEEP_SLEEP_ENABLE_OFS, 32'h2);
    xfer(1, `SLEEP_ENABLE_OFS, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      mode <= md[i];
      repeat (4) @(posedge hclk);
      `CHK("ungated", 2'b11, clk[1:0])
    end
    xfer(0, `DEEP_SLEEP_ENABLE_OFS, 0);
    `CHK("deep", 32'h2, rd)
    xfer(1, `GATING_CTRL_OFS, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      mode <= md[i];
      repeat (4) @(posedge hclk);
      `CHK("gated", ex[i], clk[1:0])
    end
    xfer(0, 8'h18, 0);
    `CHK("hole", 32'h0, rd)
    close_out;
  end
endmodule
